// file: e1_ovh_pkg.sv
// Constants, register map and carrier types for the E1 overhead event reporter
// Summary of operation
// (RULE1) Copy received X bits to spare field at CAS multiframe start; hold when unaligned.
// (RULE2) Copy received Y alarm bit to spare field at CAS multiframe start; hold when unaligned.
// (RULE3) With frame alignment, compare every 12 Sa6 bit window, first bit MSB, to five patterns.
// (RULE4) With CRC multiframe alignment and enable, compare three Sa6 codewords to same patterns.
// (RULE5) A pattern match sets its own code indication bit and the code match flag.
// (RULE6) Link id status when 2 of last 3 Sa7 bits are 0; off without frame alignment.
// (RULE7) Status bits follow their condition; either edge sets the matching flag.
// (RULE8) Sources without status set their flag directly on each event.
// (RULE9) Flags stay 1 until the host clears them; a 1 means interrupt pending.
// (RULE10) Interrupt output, active low, asserts while any flag and its enable are 1.
// (RULE11) Status, flag and enable for the eight listed alarm conditions.
// (RULE12) Flag and enable only for alignment change and the listed error events.
// (RULE13) Separate flags with enables at CRC multiframe, sub multiframe and CAS multiframe start.
// (RULE14) Five change flags with enables, one per Sa4..Sa8 codeword register.
// (RULE15) Interworking and loss flags in flag register a at 0x052 and 0x152.
// (RULE16) Error, alignment change and position flags in flag register b at 0x053 and 0x153.
// (RULE17) A 0 to 1 change of the manual reframe bit starts a frame search.
// (RULE18) Frame loss also means CAS multiframe loss; CAS search only with frame alignment.
// (RULE19) Two framers keep own registers and share one interrupt output.
// (RULE20) A write clears only selected flags; a same-cycle event keeps its flag set.
package e1_ovh_pkg;
    localparam int         NUM_FRAMERS   = 2;
    localparam logic [7:0] OFS_MODE_A    = 8'h4d;
    localparam logic [7:0] OFS_MODE_B    = 8'h4e;
    localparam logic [7:0] OFS_STATE     = 8'h4f;
    localparam logic [7:0] OFS_EN_A      = 8'h50;
    localparam logic [7:0] OFS_EN_B      = 8'h51;
    localparam logic [7:0] OFS_FLAGS_A   = 8'h52;
    localparam logic [7:0] OFS_FLAGS_B   = 8'h53;
    localparam logic [7:0] OFS_SPARE     = 8'h55;
    localparam logic [7:0] OFS_CODE_IND  = 8'h5b;
    localparam logic [7:0] OFS_SACW_EN   = 8'h5c;
    localparam logic [7:0] OFS_SACW_FLAG = 8'h5d;
    localparam logic [7:0] OFS_OVH_STATE = 8'h5f;
    localparam logic [7:0] OFS_OVH_EN    = 8'h60;
    localparam logic [7:0] OFS_OVH_FLAGS = 8'h61;
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam int         BIT_REFRAME   = 0;
    localparam int         BIT_CW_CMP    = 0;
    localparam logic [3:0] SA6_WIN_BITS  = 4'hc;
    localparam logic [1:0] CW_WIN_WORDS  = 2'h3;
    localparam logic [1:0] SA7_WIN_BITS  = 2'h3;
    localparam logic [11:0] SA6_PAT [5] = '{12'h888, 12'haaa, 12'hccc, 12'heee, 12'hfff};

    typedef struct packed {
        logic [8:0] addr;   // bit 8 selects the framer
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_t;

    typedef struct packed {
        logic offline;
        logic cas_mf_loss;
        logic crc_mf_loss;
        logic frame_loss;
        logic interwork;
    } state_t;

    typedef struct packed {
        logic cas_mf_start;
        logic crc_submf_start;
        logic crc_mf_start;
        logic align_change;
        logic cas_mf_pattern_error;
        logic crc4_error;
        logic fas_error;
        logic crc_mf_pattern_error;
    } ev_b_t;

    typedef struct packed {
        logic        frame_sync;
        logic        crc_mf_sync;
        logic        cas_mf_sync;
        logic        interwork;
        logic        offline_search;
        logic        alarm_wbe;
        logic        cont_be;
        logic        sa6_strobe;
        logic        sa6_bit;
        logic        sa7_strobe;
        logic        sa7_bit;
        logic        cw_strobe;
        logic [3:0]  cw_sa6;
        logic [19:0] sa_cw;     // Sa4 codeword in [3:0] .. Sa8 in [19:16]
        logic [2:0]  x_bits;
        logic        y_bit;
        ev_b_t       ev;
        logic        far_block_error;
        logic        nt_block_error;
        logic        nt_crc_error;
    } rx_t;
endpackage

// file: e1_overhead_event_reporter.sv
// E1 receive overhead extraction, Sa6/Sa7 detection and interrupt collection for two framers
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module e1_overhead_event_reporter
(
    input  wire  logic                                    ref_clk,        // 100 MHz clock
    input  wire  logic                                    nrst,           // Sync reset, active low
    input  wire  e1_ovh_pkg::bus_t                        bus,            // Register port
    output var   logic [7:0]                              rdata,          // Read data, cycle after rd
    input  wire  e1_ovh_pkg::rx_t [e1_ovh_pkg::NUM_FRAMERS-1:0] rx,       // Framer core state per framer
    output var   logic                                    irq_n,          // Shared interrupt, active low
    output var   logic [e1_ovh_pkg::NUM_FRAMERS-1:0]      reframe_start   // One-cycle manual search pulse
);
    import e1_ovh_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic hit(bus_t b, int fr, logic [7:0] ofs);
        return (b.addr[8] == fr[0]) && (b.addr[7:0] == ofs);
    endfunction

    // Set wins over a clearing write so no event is lost
    function automatic logic [7:0] upd(logic [7:0] f, logic [7:0] set, logic clr, logic [7:0] w);
        return (f & ~(clr ? w : 8'h00)) | set;
    endfunction

    function automatic logic [4:0] match5(logic [11:0] w);
        logic [4:0] m;
        m = 5'h00;
        for (int i = 0; i < 5; i++)
        begin
            m[i] = (w == SA6_PAT[i]);
        end
        return m;
    endfunction

    logic [7:0] rd_val [NUM_FRAMERS];
    logic       pend   [NUM_FRAMERS];
    logic       rf_req [NUM_FRAMERS];

    ////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < NUM_FRAMERS; g++)
    begin : fr
        logic [7:0]  mode_a;
        logic [7:0]  mode_b;
        logic [7:0]  en_a;
        logic [7:0]  en_b;
        logic [7:0]  sacw_en;
        logic [7:0]  ovh_en;
        logic [7:0]  flags_a;
        logic [7:0]  flags_b;
        logic [7:0]  sacw_flags;
        logic [7:0]  ovh_flags;
        logic [7:0]  code_ind;
        state_t      st;
        state_t      st_q;
        logic [2:0]  ov;
        logic [2:0]  ov_q;
        logic [2:0]  x_spare;
        logic        y_spare;
        logic        cas_ok;
        logic [11:0] sa6_sh;
        logic [11:0] next_sa6;
        logic [3:0]  sa6_cnt;
        logic [11:0] cw_sh;
        logic [11:0] next_cw;
        logic [1:0]  cw_cnt;
        logic [2:0]  sa7_sh;
        logic [2:0]  next_sa7;
        logic [1:0]  sa7_cnt;
        logic        link_id_state;
        logic [4:0]  seq_hit;
        logic [4:0]  cw_hit;
        logic [4:0]  sacw_chg;
        logic [19:0] cw_prev;
        logic        reframe_q;
        logic        wr_g;

        assign wr_g = bus.wr;
        // Frame loss forces CAS multiframe loss as well
        assign cas_ok = rx[g].cas_mf_sync & rx[g].frame_sync;   // see (RULE18)
        assign st = '{offline:     rx[g].offline_search,
                      cas_mf_loss: ~cas_ok,
                      crc_mf_loss: ~(rx[g].crc_mf_sync & rx[g].frame_sync),
                      frame_loss:  ~rx[g].frame_sync,
                      interwork:   rx[g].interwork};             // see (RULE11)
        assign ov = {link_id_state, rx[g].cont_be, rx[g].alarm_wbe};

        ////////////////////////////////////////////////////////////////////////
        // Host control registers
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
            begin
                mode_a  <= RST_REG;
                mode_b  <= RST_REG;
                en_a    <= RST_REG;
                en_b    <= RST_REG;
                sacw_en <= RST_REG;
                ovh_en  <= RST_REG;
            end
            else if (wr_g)
            begin
                if (hit(bus, g, OFS_MODE_A))
                    mode_a <= bus.wdata;
                if (hit(bus, g, OFS_MODE_B))
                    mode_b <= bus.wdata;
                if (hit(bus, g, OFS_EN_A))
                    en_a <= bus.wdata;
                if (hit(bus, g, OFS_EN_B))
                    en_b <= bus.wdata;
                if (hit(bus, g, OFS_SACW_EN))
                    sacw_en <= bus.wdata;
                if (hit(bus, g, OFS_OVH_EN))
                    ovh_en <= bus.wdata;
            end
        end

        // Only a rising edge of the bit starts a search; rewriting 1 does nothing
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
                reframe_q <= 1'b0;
            else
                reframe_q <= mode_a[BIT_REFRAME];
        end
        assign rf_req[g] = mode_a[BIT_REFRAME] & ~reframe_q;   // see (RULE17)

        ////////////////////////////////////////////////////////////////////////
        // TS16 spare bits
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
            begin
                x_spare <= 3'h0;
                y_spare <= 1'b0;
            end
            else if (rx[g].ev.cas_mf_start && cas_ok)
            begin
                x_spare <= rx[g].x_bits;   // see (RULE1)
                y_spare <= rx[g].y_bit;    // see (RULE2)
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Sa6 bit window and codeword window
        assign next_sa6 = {sa6_sh[10:0], rx[g].sa6_bit};
        assign next_cw  = {cw_sh[7:0], rx[g].cw_sa6};
        assign seq_hit  = (rx[g].frame_sync && rx[g].sa6_strobe && sa6_cnt >= SA6_WIN_BITS - 4'h1)
                          ? match5(next_sa6) : 5'h00;                                     // see (RULE3)
        assign cw_hit   = (rx[g].crc_mf_sync && mode_b[BIT_CW_CMP] && rx[g].cw_strobe
                           && cw_cnt >= CW_WIN_WORDS - 2'h1) ? match5(next_cw) : 5'h00;  // see (RULE4)

        always_ff @(posedge ref_clk)
        begin
            if (!nrst || !rx[g].frame_sync)
            begin
                sa6_sh  <= 12'h000;
                sa6_cnt <= 4'h0;
            end
            else if (rx[g].sa6_strobe)
            begin
                sa6_sh  <= next_sa6;
                sa6_cnt <= (sa6_cnt == SA6_WIN_BITS) ? sa6_cnt : sa6_cnt + 4'h1;
            end
        end

        // Window restarts when alignment or the enable drops
        always_ff @(posedge ref_clk)
        begin
            if (!nrst || !rx[g].crc_mf_sync || !mode_b[BIT_CW_CMP])
            begin
                cw_sh  <= 12'h000;
                cw_cnt <= 2'h0;
            end
            else if (rx[g].cw_strobe)
            begin
                cw_sh  <= next_cw;
                cw_cnt <= (cw_cnt == CW_WIN_WORDS) ? cw_cnt : cw_cnt + 2'h1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Sa7 link identification, 2 of 3 zeros
        assign next_sa7 = {sa7_sh[1:0], rx[g].sa7_bit};
        always_ff @(posedge ref_clk)
        begin
            if (!nrst || !rx[g].frame_sync)
            begin
                sa7_sh        <= 3'h0;
                sa7_cnt       <= 2'h0;
                link_id_state <= 1'b0;   // see (RULE6)
            end
            else if (rx[g].sa7_strobe)
            begin
                sa7_sh        <= next_sa7;
                sa7_cnt       <= (sa7_cnt == SA7_WIN_BITS) ? sa7_cnt : sa7_cnt + 2'h1;
                link_id_state <= (sa7_cnt >= SA7_WIN_BITS - 2'h1)
                                 && ((~next_sa7[0] & ~next_sa7[1]) | (~next_sa7[0] & ~next_sa7[2])
                                     | (~next_sa7[1] & ~next_sa7[2]));                   // see (RULE6)
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Status history and codeword history for change detection
        // Reset history is all clear, so a loss present at release flags at once
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
            begin
                st_q    <= '0;
                ov_q    <= 3'h0;
                cw_prev <= 20'h00000;
            end
            else
            begin
                st_q    <= st;
                ov_q    <= ov;
                cw_prev <= rx[g].sa_cw;
            end
        end

        for (genvar k = 0; k < 5; k++)
        begin : cwc
            assign sacw_chg[k] = (rx[g].sa_cw[4*k +: 4] != cw_prev[4*k +: 4]);   // see (RULE14)
        end

        ////////////////////////////////////////////////////////////////////////
        // Sticky flags
        always_ff @(posedge ref_clk)
        begin
            if (!nrst)
            begin
                flags_a    <= RST_REG;
                flags_b    <= RST_REG;
                sacw_flags <= RST_REG;
                ovh_flags  <= RST_REG;
                code_ind   <= RST_REG;
            end
            else
            begin
                flags_a    <= upd(flags_a, {3'h0, st ^ st_q},
                                  wr_g && hit(bus, g, OFS_FLAGS_A), bus.wdata);   // see (RULE7) (RULE15) (RULE20)
                flags_b    <= upd(flags_b, rx[g].ev,
                                  wr_g && hit(bus, g, OFS_FLAGS_B), bus.wdata);   // see (RULE8) (RULE12) (RULE13) (RULE16)
                sacw_flags <= upd(sacw_flags, {3'h0, sacw_chg},
                                  wr_g && hit(bus, g, OFS_SACW_FLAG), bus.wdata); // see (RULE14)
                ovh_flags  <= upd(ovh_flags,
                                  {1'b0, |(seq_hit | cw_hit), ov[2] ^ ov_q[2], rx[g].nt_crc_error,
                                   rx[g].nt_block_error, ov[1:0] ^ ov_q[1:0], rx[g].far_block_error},
                                  wr_g && hit(bus, g, OFS_OVH_FLAGS), bus.wdata); // see (RULE5) (RULE7) (RULE8)
                code_ind   <= upd(code_ind, {3'h0, seq_hit | cw_hit},
                                  wr_g && hit(bus, g, OFS_CODE_IND), bus.wdata);  // see (RULE5) (RULE9)
            end
        end

        assign pend[g] = |(flags_a & en_a) | |(flags_b & en_b)
                         | |(sacw_flags & sacw_en) | |(ovh_flags & ovh_en);       // see (RULE9) (RULE10)

        ////////////////////////////////////////////////////////////////////////
        // Read multiplexer
        always_comb
        begin
            case (bus.addr[7:0])
                OFS_MODE_A:    rd_val[g] = mode_a;
                OFS_MODE_B:    rd_val[g] = mode_b;
                OFS_STATE:     rd_val[g] = {3'h0, st};
                OFS_EN_A:      rd_val[g] = en_a;
                OFS_EN_B:      rd_val[g] = en_b;
                OFS_FLAGS_A:   rd_val[g] = flags_a;
                OFS_FLAGS_B:   rd_val[g] = flags_b;
                OFS_SPARE:     rd_val[g] = {4'h0, y_spare, x_spare};
                OFS_CODE_IND:  rd_val[g] = code_ind;
                OFS_SACW_EN:   rd_val[g] = sacw_en;
                OFS_SACW_FLAG: rd_val[g] = sacw_flags;
                OFS_OVH_STATE: rd_val[g] = {5'h00, ov};
                OFS_OVH_EN:    rd_val[g] = ovh_en;
                OFS_OVH_FLAGS: rd_val[g] = ovh_flags;
                default:       rd_val[g] = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared outputs; read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rdata         <= 8'h00;
            irq_n         <= 1'b1;
            reframe_start <= '0;
        end
        else
        begin
            rdata         <= bus.rd ? rd_val[bus.addr[8]] : 8'h00;
            irq_n         <= ~(pend[0] | pend[1]);       // see (RULE10) (RULE19)
            reframe_start <= {rf_req[1], rf_req[0]};     // see (RULE17)
        end
    end
endmodule // e1_overhead_event_reporter
`default_nettype wire

// file: e1_ovh_sva.sv
// Port-level assertions for the E1 overhead event reporter
`timescale 1ns/1ps
`default_nettype none
module e1_ovh_sva
    import e1_ovh_pkg::*;
(
    input wire logic                              ref_clk,       // Clock
    input wire logic                              nrst,          // Sync reset, active low
    input wire e1_ovh_pkg::bus_t                  bus,           // Register port
    input wire logic [7:0]                        rdata,         // Read data
    input wire e1_ovh_pkg::rx_t [NUM_FRAMERS-1:0] rx,            // Framer core inputs
    input wire logic                              irq_n,         // Shared interrupt
    input wire logic [NUM_FRAMERS-1:0]            reframe_start  // Manual search pulses
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    rx_t [NUM_FRAMERS-1:0] rx_d;
    logic [1:0]            quiet;
    logic [4:0]            st0;

    // Loss levels as the framer state register should show them
    assign st0 = {rx[0].offline_search, ~rx[0].cas_mf_sync | ~rx[0].frame_sync,
                  ~rx[0].crc_mf_sync | ~rx[0].frame_sync, ~rx[0].frame_sync, rx[0].interwork};

    // Cycles with no write and no input change; irq_n may move up to three cycles after a cause
    always_ff @(posedge ref_clk)
    begin
        rx_d <= rx;
        if (!nrst || bus.wr || rx != rx_d)
            quiet <= 2'h0;
        else if (quiet != 2'h3)
            quiet <= quiet + 2'h1;
    end

    sequence state_read_s;
        $past(bus.rd) && $past(bus.addr) == {1'b0, OFS_STATE} && $past(nrst, 2);
    endsequence

    property reframe_cause_p(logic sel, logic pulse);
        pulse |-> $past(bus.wr, 2) && $past(bus.addr, 2) == {sel, OFS_MODE_A} && $past(bus.wdata[0], 2);
    endproperty

    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_state_read_live: assert property (state_read_s |-> rdata == {3'h0, $past(st0)})
        else $error("framer state read differs from loss levels");
    a_reframe_once_only: assert property (|reframe_start |=> (reframe_start & $past(reframe_start)) == '0)
        else $error("reframe pulse longer than one cycle");
    a_reframe_cause_first: assert property (reframe_cause_p(1'b0, reframe_start[0]))
        else $error("framer 0 search pulse without mode write");
    a_reframe_cause_second: assert property (reframe_cause_p(1'b1, reframe_start[1]))
        else $error("framer 1 search pulse without mode write");
    a_irq_release_write: assert property ($rose(irq_n) |-> $past(bus.wr, 2))
        else $error("interrupt released without a host write");
    a_irq_quiet_hold: assert property (quiet == 2'h3 |-> $stable(irq_n))
        else $error("interrupt moved without any cause");
    a_reset_outputs_idle: assert property ($rose(nrst) |-> irq_n && rdata == 8'h00 && reframe_start == '0)
        else $error("outputs not idle after reset");
endmodule // e1_ovh_sva

bind e1_overhead_event_reporter e1_ovh_sva chk
(
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .bus           (bus),
    .rdata         (rdata),
    .rx            (rx),
    .irq_n         (irq_n),
    .reframe_start (reframe_start)
);
`default_nettype wire

// file: e1_line_model.sv
// Far-end E1 line model: drives received overhead and framing levels per framer
`timescale 1ns/1ps
`default_nettype none
module e1_line_model
    import e1_ovh_pkg::*;
(
    input  wire logic                              ref_clk, // Line clock
    output var  e1_ovh_pkg::rx_t [NUM_FRAMERS-1:0] rx       // Received overhead per framer
);
    initial
    begin
        rx = '0;
        for (int g = 0; g < NUM_FRAMERS; g++)
            {rx[g].frame_sync, rx[g].crc_mf_sync, rx[g].cas_mf_sync} = 3'h7;
    end

    // Alignment levels {frame, crc multiframe, cas multiframe}
    task automatic lvl(input int g, input logic [2:0] s);
        @(posedge ref_clk);
        {rx[g].frame_sync, rx[g].crc_mf_sync, rx[g].cas_mf_sync} <= s;
    endtask

    // One received Sa6 bit (kind 0), Sa7 bit (kind 1) or Sa6 codeword (kind 2)
    task automatic slot(input int g, input int kind, input logic [3:0] v);
        @(posedge ref_clk);
        case (kind)
            0: {rx[g].sa6_strobe, rx[g].sa6_bit} <= {1'b1, v[0]};
            1: {rx[g].sa7_strobe, rx[g].sa7_bit} <= {1'b1, v[0]};
            default: {rx[g].cw_strobe, rx[g].cw_sa6} <= {1'b1, v};
        endcase
        @(posedge ref_clk);
        // Released data shows the inverse so a stale bit is never read as fresh
        {rx[g].sa6_strobe, rx[g].sa7_strobe, rx[g].cw_strobe} <= 3'h0;
        {rx[g].sa6_bit, rx[g].sa7_bit, rx[g].cw_sa6} <= ~{rx[g].sa6_bit, rx[g].sa7_bit, rx[g].cw_sa6};
    endtask

    // Event pulses; extra and alarm bits {x, y} stand only beside the pulse
    task automatic pulse(input int g, input logic [7:0] e, input logic [3:0] xy);
        @(posedge ref_clk);
        rx[g].ev <= ev_b_t'(e);
        {rx[g].x_bits, rx[g].y_bit} <= xy;
        @(posedge ref_clk);
        rx[g].ev <= '0;
        {rx[g].x_bits, rx[g].y_bit} <= ~xy;
    endtask

    // Levels {interwork, offline, alarm, continuous} stay; events {far, nt block, nt crc} pulse once
    task automatic cond(input int g, input logic [3:0] lv, input logic [2:0] e);
        @(posedge ref_clk);
        {rx[g].interwork, rx[g].offline_search, rx[g].alarm_wbe, rx[g].cont_be} <= lv;
        {rx[g].far_block_error, rx[g].nt_block_error, rx[g].nt_crc_error} <= e;
        @(posedge ref_clk);
        {rx[g].far_block_error, rx[g].nt_block_error, rx[g].nt_crc_error} <= 3'h0;
    endtask

    task automatic sacw(input int g, input logic [19:0] v);
        @(posedge ref_clk);
        rx[g].sa_cw <= v;
    endtask
endmodule // e1_line_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the E1 overhead event reporter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import e1_ovh_pkg::*;
    logic                        ref_clk;
    logic                        nrst;
    bus_t                        bus;
    logic [7:0]                  rdata;
    rx_t [NUM_FRAMERS-1:0]       rx;
    logic                        irq_n;
    logic [NUM_FRAMERS-1:0]      reframe_start;
    int                          n_mismatch;
    int                          comparisons;
    int                          pulses;

    e1_overhead_event_reporter dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .rx(rx),
                                    .irq_n(irq_n), .reframe_start(reframe_start));
    e1_line_model line (.ref_clk(ref_clk), .rx(rx));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Framer 1 pulses weigh 16 so one count shows both outputs
    always @(posedge ref_clk)
    begin
        if (reframe_start[0] === 1'b1)
            pulses++;
        if (reframe_start[1] === 1'b1)
            pulses += 16;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // Interrupt settles within three cycles of its cause
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge ref_clk);
        #1 chk({7'h0, irq_n}, {7'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(9'h04d, 8'h00);
        rd(9'h050, 8'h00);
        rd(9'h051, 8'h00);
        rd(9'h052, 8'h00);
        rd(9'h053, 8'h00);
        wr(9'h04f, 8'hff);
        rd(9'h04f, 8'h00);
        rd(9'h07f, 8'h00);
        irq_is(1'b1);
    endtask

    task automatic t_loss;
        wr(9'h050, 8'h02);
        line.lvl(0, 3'h3);
        rd(9'h052, 8'h0e);
        rd(9'h04f, 8'h0e);
        irq_is(1'b0);
        wr(9'h052, 8'h02);
        rd(9'h052, 8'h0c);
        irq_is(1'b1);
        line.lvl(0, 3'h7);
        rd(9'h052, 8'h0e);
        wr(9'h052, 8'hff);
        wr(9'h050, 8'h00);
    endtask

    task automatic t_events;
        for (int i = 0; i < 8; i++)
        begin
            line.pulse(0, 8'h01 << i, 4'h0);
            rd(9'h053, 8'((16'h2 << i) - 16'h1));
        end
        wr(9'h053, 8'hff);
        fork
            line.pulse(0, 8'h02, 4'h0);
            wr(9'h053, 8'h02);
        join
        rd(9'h053, 8'h02);
        wr(9'h053, 8'h02);
        wr(9'h151, 8'h80);
        line.pulse(1, 8'h80, 4'h0);
        rd(9'h153, 8'h80);
        rd(9'h053, 8'h00);
        irq_is(1'b0);
        wr(9'h153, 8'h80);
        irq_is(1'b1);
    endtask

    task automatic t_sa6;
        for (int k = 0; k < 5; k++)
        begin
            line.lvl(0, 3'h3);
            line.lvl(0, 3'h7);
            for (int b = 11; b >= 0; b--)
                line.slot(0, 0, {3'h0, SA6_PAT[k][b]});
            rd(9'h05b, 8'h01 << k);
            wr(9'h05b, 8'h1f);
        end
        rd(9'h061, 8'h40);
        wr(9'h061, 8'hff);
        wr(9'h052, 8'hff);
        wr(9'h04e, 8'h01);
        repeat (3) line.slot(0, 2, 4'he);
        rd(9'h05b, 8'h08);
        rd(9'h061, 8'h40);
        wr(9'h061, 8'hff);
    endtask

    task automatic t_link_spare;
        line.slot(0, 1, 4'h1);
        line.slot(0, 1, 4'h0);
        line.slot(0, 1, 4'h0);
        rd(9'h05f, 8'h04);
        rd(9'h061, 8'h20);
        line.lvl(0, 3'h3);
        rd(9'h05f, 8'h00);
        line.lvl(0, 3'h7);
        line.pulse(0, 8'h80, 4'hb);
        rd(9'h055, 8'h0d);
        line.lvl(0, 3'h6);
        line.pulse(0, 8'h80, 4'h4);
        rd(9'h055, 8'h0d);
        line.lvl(0, 3'h7);
        line.sacw(0, 20'h000a0);
        rd(9'h05d, 8'h02);
        wr(9'h060, 8'h1f);
        line.cond(0, 4'hf, 3'h7);
        rd(9'h061, 8'h3f);
        rd(9'h05f, 8'h03);
        rd(9'h04f, 8'h11);
        irq_is(1'b0);
        wr(9'h061, 8'hff);
        irq_is(1'b1);
    endtask

    task automatic t_reframe;
        pulses = 0;
        wr(9'h04d, 8'h01);
        wr(9'h04d, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk(8'(pulses), 8'h01);
        wr(9'h04d, 8'h00);
        wr(9'h04d, 8'h01);
        wr(9'h14d, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk(8'(pulses), 8'h12);
    endtask

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        bus = '0;
        nrst = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        pulses = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_loss();
        t_events();
        t_sa6();
        t_link_spare();
        t_reframe();
        end_sim();
    end

    // The full sequence needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
